// *** verilog/dtc_pkg.sv ***
// Constants, field positions and carrier types for the dual timer/counter.
// Assumes an APB slave with 32-bit data; registers are one word each.
package dtc_pkg;
  // ==========================================================
  // Register indices (printed offsets) and byte address width
  localparam logic [7:0] IDX_RUNFLAG = 8'h88;
  localparam logic [7:0] IDX_MODECFG = 8'h89;
  localparam logic [7:0] IDX_A_LOW = 8'h8a;
  localparam logic [7:0] IDX_B_LOW = 8'h8b;
  localparam logic [7:0] IDX_A_HIGH = 8'h8c;
  localparam logic [7:0] IDX_B_HIGH = 8'h8d;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h90;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h91;
  localparam int ADDR_W = 12;
  // ==========================================================
  // Run and flag control bit positions
  localparam int B_OVF = 7;
  localparam int B_RUN = 6;
  localparam int A_OVF = 5;
  localparam int A_RUN = 4;
  localparam int B_EXF = 3;
  localparam int B_TYP = 2;
  localparam int A_EXF = 1;
  localparam int A_TYP = 0;
  // Mode configuration: per-timer nibble positions
  localparam int B_NIB = 4;
  localparam int A_NIB = 0;
  localparam int N_GATE = 3;
  localparam int N_SRC = 2;
  // Interrupt status bit positions
  localparam int S_A_OVF = 0;
  localparam int S_B_OVF = 1;
  localparam int S_A_EXT = 2;
  localparam int S_B_EXT = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;
  // ==========================================================
  // Operating modes
  typedef enum logic [1:0]
  {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD = 2'b10,
    MODE_SPLIT = 2'b11
  } dtc_mode_t;
  // Per-timer control nibble
  typedef struct packed
  {
    logic gate;
    logic src;
    dtc_mode_t mode;
  } dtc_cfg_t;
  // Pin group
  typedef struct packed
  {
    logic irqB;
    logic irqA;
    logic cntB;
    logic cntA;
  } dtc_pins_t;
endpackage : dtc_pkg

// *** verilog/dtc_timer.sv ***
// Dual 8-bit-pair timer/counter with external interrupt detect.
// Assumes an APB master on mclk and pins asynchronous inputs needing retiming.
`timescale 1ns/10ps
module dtc_timer
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins
  input wire dtc_pins_t pins,
  // Interrupt vector acknowledges
  input wire logic vecAckA,
  input wire logic vecAckB,
  input wire logic vecExtA,
  input wire logic vecExtB,
  // Interrupt output
  output logic irq
);
  // ==========================================================
  // Functions
  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    is_addr = (a == {2'b00, idx, 2'b00});
  endfunction : is_addr

  // ==========================================================
  // Storage
  logic [7:0] runFlag_q;
  logic [7:0] modeCfg_q;
  logic [7:0] aLow_q, aHigh_q, bLow_q, bHigh_q;
  logic [3:0] irqStat_q, irqMask_q;
  logic [31:0] prdata_q;
  dtc_pins_t sync1_q, sync2_q, prev_q;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sync1_q <= '1;
      sync2_q <= '1;
      prev_q <= '1;
    end
    else
    begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  wire dtc_pins_t fall = prev_q & ~sync2_q;

  // ==========================================================
  // Bus decode
  wire logic acc = psel & penable;
  wire logic wrEn = acc & pwrite & pstrb[0];
  wire logic hitRun = is_addr(paddr, IDX_RUNFLAG);
  wire logic hitMode = is_addr(paddr, IDX_MODECFG);
  wire logic hitAL = is_addr(paddr, IDX_A_LOW);
  wire logic hitBL = is_addr(paddr, IDX_B_LOW);
  wire logic hitAH = is_addr(paddr, IDX_A_HIGH);
  wire logic hitBH = is_addr(paddr, IDX_B_HIGH);
  wire logic hitStat = is_addr(paddr, IDX_IRQ_STAT);
  wire logic hitMask = is_addr(paddr, IDX_IRQ_MASK);
  wire logic hitAny = hitRun | hitMode | hitAL | hitBL | hitAH | hitBH | hitStat | hitMask;
  wire logic [7:0] wb = pwdata[7:0];
  assign pready = 1'b1;
  assign pslverr = acc & ~hitAny;

  // ==========================================================
  // Control decode
  wire dtc_cfg_t cfgA = dtc_cfg_t'(modeCfg_q[A_NIB +: 4]);
  wire dtc_cfg_t cfgB = dtc_cfg_t'(modeCfg_q[B_NIB +: 4]);
  wire logic runA = runFlag_q[A_RUN];
  wire logic runB = runFlag_q[B_RUN];
  wire logic enA = runA & (~cfgA.gate | sync2_q.irqA);
  wire logic enB = runB & (~cfgB.gate | sync2_q.irqB);
  wire logic tickA = enA & (cfgA.src ? fall.cntA : 1'b1);
  wire logic tickB = enB & (cfgB.src ? fall.cntB : 1'b1);
  wire logic splitA = (cfgA.mode == MODE_SPLIT);
  wire logic tickAH = splitA & runB;

  // ==========================================================
  // Counter step: returns {overflow, high, low}
  function automatic logic [16:0] step(input dtc_mode_t m, input logic [7:0] lo,
                                       input logic [7:0] hi);
    logic [16:0] r;
    logic [12:0] c13;
    logic [16:0] c16;
    logic [8:0] c8;
    r = {1'b0, hi, lo};
    c13 = 13'({hi, lo[4:0]}) + 13'd1;
    c16 = {1'b0, hi, lo} + 17'd1;
    c8 = {1'b0, lo} + 9'd1;
    case (m)
      MODE_13BIT: r = {({hi, lo[4:0]} == 13'h1fff), c13[12:5], lo[7:5], c13[4:0]};
      MODE_16BIT: r = c16;
      MODE_RELOAD: r = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
      MODE_SPLIT: r = {c8[8], hi, c8[7:0]};
      default: r = {1'b0, hi, lo};
    endcase
    step = r;
  endfunction : step

  wire logic [16:0] nxtA = step(cfgA.mode, aLow_q, aHigh_q);
  wire logic [16:0] nxtB = step(cfgB.mode, bLow_q, bHigh_q);
  wire logic [8:0] nxtAH = {1'b0, aHigh_q} + 9'd1;
  wire logic stopB = (cfgB.mode == MODE_SPLIT);
  wire logic doB = tickB & ~stopB;
  wire logic ovfA = tickA & nxtA[16];
  wire logic ovfB = splitA ? (tickAH & nxtAH[8]) : (doB & nxtB[16]);

  // ==========================================================
  // Counter registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aLow_q <= RST_BYTE;
      aHigh_q <= RST_BYTE;
      bLow_q <= RST_BYTE;
      bHigh_q <= RST_BYTE;
    end
    else
    begin
      if (wrEn & hitAL)
        aLow_q <= wb;
      else if (tickA)
        aLow_q <= nxtA[7:0];
      if (wrEn & hitAH)
        aHigh_q <= wb;
      else if (splitA & tickAH)
        aHigh_q <= nxtAH[7:0];
      else if (~splitA & tickA)
        aHigh_q <= nxtA[15:8];
      if (wrEn & hitBL)
        bLow_q <= wb;
      else if (doB)
        bLow_q <= nxtB[7:0];
      if (wrEn & hitBH)
        bHigh_q <= wb;
      else if (doB)
        bHigh_q <= nxtB[15:8];
    end
  end

  // ==========================================================
  // External interrupt flags
  wire logic trigA = runFlag_q[A_TYP] ? fall.irqA : ~sync2_q.irqA;
  wire logic trigB = runFlag_q[B_TYP] ? fall.irqB : ~sync2_q.irqB;
  wire logic wrRun = wrEn & hitRun;

  function automatic logic flag_nxt(input logic cur, input logic wr, input logic wv,
                                    input logic set, input logic clr);
    logic f;
    f = cur;
    if (wr)
      f = wv;
    else if (clr)
      f = 1'b0;
    if (set)
      f = 1'b1;
    flag_nxt = f;
  endfunction : flag_nxt

  wire logic extA = runFlag_q[A_TYP] ?
    flag_nxt(runFlag_q[A_EXF], wrRun, wb[A_EXF], trigA, vecExtA) : trigA;
  wire logic extB = runFlag_q[B_TYP] ?
    flag_nxt(runFlag_q[B_EXF], wrRun, wb[B_EXF], trigB, vecExtB) : trigB;
  wire logic [7:0] runFlag_d =
  {
    flag_nxt(runFlag_q[B_OVF], wrRun, wb[B_OVF], ovfB, vecAckB),
    wrRun ? wb[B_RUN] : runFlag_q[B_RUN],
    flag_nxt(runFlag_q[A_OVF], wrRun, wb[A_OVF], ovfA, vecAckA),
    wrRun ? wb[A_RUN] : runFlag_q[A_RUN],
    extB,
    wrRun ? wb[B_TYP] : runFlag_q[B_TYP],
    extA,
    wrRun ? wb[A_TYP] : runFlag_q[A_TYP]
  };

  // ==========================================================
  // Control and interrupt registers
  wire logic [3:0] evt = {trigB & ~runFlag_q[B_EXF], trigA & ~runFlag_q[A_EXF], ovfB, ovfA};
  wire logic [3:0] statClr = (wrEn & hitStat) ? wb[3:0] : 4'h0;
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      runFlag_q <= RST_BYTE;
      modeCfg_q <= RST_BYTE;
      irqStat_q <= RST_IRQ;
      irqMask_q <= RST_IRQ;
    end
    else
    begin
      runFlag_q <= runFlag_d;
      if (wrEn & hitMode)
        modeCfg_q <= wb;
      if (wrEn & hitMask)
        irqMask_q <= wb[3:0];
      irqStat_q <= (irqStat_q & ~statClr) | evt;
    end
  end
  assign irq = |(irqStat_q & irqMask_q);

  // ==========================================================
  // Read data
  wire logic [7:0] rdSel =
    hitRun ? runFlag_q :
    hitMode ? modeCfg_q :
    hitAL ? aLow_q :
    hitBL ? bLow_q :
    hitAH ? aHigh_q :
    hitBH ? bHigh_q :
    hitStat ? {4'h0, irqStat_q} :
    hitMask ? {4'h0, irqMask_q} : 8'h00;
  always_ff @(posedge mclk)
  begin
    if (srst)
      prdata_q <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata_q <= {24'h00_0000, rdSel};
  end
  assign prdata = prdata_q;
endmodule : dtc_timer

// *** dv/dtc_timer_sva.sv ***
// Port checker for the dual timer: APB answers and interrupt level.
// Assumes bind onto dtc_timer; one clock, sync reset.
`timescale 1ns/10ps
module dtc_timer_sva
  import dtc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Vectors and interrupt
  input wire logic vecAckA,
  input wire logic vecAckB,
  input wire logic vecExtA,
  input wire logic vecExtB,
  input wire logic irq
);
  // ========
  // Decode
  wire logic [7:0] idx = paddr[9:2];
  wire logic acc = psel && penable && paddr[1:0] == 2'b00;
  wire logic hit = (idx >= IDX_RUNFLAG && idx <= IDX_B_HIGH) || idx == IDX_IRQ_STAT
    || idx == IDX_IRQ_MASK;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  // ========
  // Properties
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && !hit |-> pslverr)
    else $error("no error on unmapped");
  a_no_err: assert property (acc && hit |-> !pslverr)
    else $error("error on mapped");
  a_read_zero: assert property (acc && !pwrite && !hit |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_data_held: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite)
    || $past(srst))
    else $error("read data moved");
  a_irq_reset: assert property ($past(srst) |-> !irq)
    else $error("irq after reset");
  a_irq_drop: assert property ($fell(irq) |-> $past(psel && penable && pwrite) || $past(srst)
    || $past(vecAckA || vecAckB || vecExtA || vecExtB))
    else $error("irq fell unprompted");
endmodule : dtc_timer_sva
bind dtc_timer dtc_timer_sva u_dtc_timer_sva (.mclk(mclk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .vecAckA(vecAckA), .vecAckB(vecAckB), .vecExtA(vecExtA),
  .vecExtB(vecExtB), .irq(irq));

// *** dv/dtc_pin_model.sv ***
// Model of the external count and interrupt pins.
// Assumes the bench sets wanted levels; pins move on mclk only.
`timescale 1ns/10ps
module dtc_pin_model
  import dtc_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Wanted levels and pins
  input wire dtc_pins_t want,
  output dtc_pins_t pins
);
  // ========
  // Levels held for whole cycles
  always_ff @(posedge mclk)
    pins <= want;
endmodule : dtc_pin_model

// *** dv/test_dual_timer_counter_ext_irq.sv ***
// Bench for the dual timer: APB calls with expected values.
// Assumes dtc_timer, the pin model and the bound checker.
`timescale 1ns/10ps
module test_dual_timer_counter_ext_irq
  import dtc_pkg::*;
;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic vecAckA, vecAckB, vecExtA, vecExtB;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  dtc_pins_t want, pins;
  int fails, compares;
  logic [7:0] idxs [8] = '{IDX_RUNFLAG, IDX_MODECFG, IDX_A_LOW, IDX_B_LOW, IDX_A_HIGH,
    IDX_B_HIGH, IDX_IRQ_STAT, IDX_IRQ_MASK};
  dtc_timer u_dtc_timer (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .vecAckA(vecAckA), .vecAckB(vecAckB),
    .vecExtA(vecExtA), .vecExtB(vecExtB), .irq(irq));
  dtc_pin_model u_dtc_pin_model (.mclk(mclk), .want(want), .pins(pins));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ========
  // Tasks
  task automatic final_report();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge mclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20)
    begin
      fails++;
      final_report();
    end
    @(posedge mclk);
  endtask : apb
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
  endtask : rdc
  task automatic wait_irq();
    int n;
    for (n = 0; n < 600 && irq !== 1'b1; n++)
      @(posedge mclk);
    check({31'h0000_0000, irq}, 32'h0000_0001);
    if (irq !== 1'b1)
      final_report();
  endtask : wait_irq
  task automatic edges(input int n);
    repeat (n)
    begin
      want.cntA <= 1'b1;
      cyc(2);
      want.cntA <= 1'b0;
      cyc(2);
    end
    cyc(5);
  endtask : edges
  task automatic edges_b(input int n);
    repeat (n)
    begin
      want.cntB <= 1'b1;
      cyc(2);
      want.cntB <= 1'b0;
      cyc(2);
    end
    cyc(5);
  endtask : edges_b
  // ========
  // Sequence
  initial
  begin
    {srst, psel, penable, pwrite, vecAckA, vecAckB, vecExtA, vecExtB} = 8'h80;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hF;
    want = 4'hF;
    fails = 0;
    compares = 0;
    cyc(3);
    srst <= 1'b0;
    @(posedge mclk);
    foreach (idxs[i]) rdc(idxs[i], 32'h0000_0000);
    apb(1'b0, 8'h8e, 32'h0000_0000);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, IDX_A_LOW, 32'hFFFF_FF5A);
    rdc(IDX_A_LOW, 32'h0000_005A);
    pstrb <= 4'hE;
    apb(1'b1, IDX_B_HIGH, 32'h0000_0077);
    pstrb <= 4'hF;
    rdc(IDX_B_HIGH, 32'h0000_0000);
    apb(1'b1, IDX_A_HIGH, 32'h0000_00FF);
    apb(1'b1, IDX_A_LOW, 32'h0000_00FE);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0010);
    cyc(4);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    rdc(IDX_RUNFLAG, 32'h0000_0030);
    rdc(IDX_A_HIGH, 32'h0000_0000);
    apb(1'b0, IDX_A_LOW, 32'h0000_0000);
    check(rd & 32'h0000_00E0, 32'h0000_00E0);
    rdc(IDX_IRQ_STAT, 32'h0000_0001);
    apb(1'b1, IDX_IRQ_MASK, 32'h0000_000F);
    wait_irq();
    vecAckA <= 1'b1;
    @(posedge mclk);
    vecAckA <= 1'b0;
    @(posedge mclk);
    rdc(IDX_RUNFLAG, 32'h0000_0010);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0000);
    apb(1'b1, IDX_IRQ_STAT, 32'h0000_000F);
    check({31'h0000_0000, irq}, 32'h0000_0000);
    apb(1'b1, IDX_MODECFG, 32'h0000_0020);
    apb(1'b1, IDX_B_HIGH, 32'h0000_00F0);
    apb(1'b1, IDX_B_LOW, 32'h0000_00FE);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0040);
    wait_irq();
    rdc(IDX_B_HIGH, 32'h0000_00F0);
    apb(1'b0, IDX_B_LOW, 32'h0000_0000);
    check(rd & 32'h0000_00F0, 32'h0000_00F0);
    rdc(IDX_IRQ_STAT, 32'h0000_0002);
    apb(1'b1, IDX_MODECFG, 32'h0000_003D);
    apb(1'b1, IDX_B_LOW, 32'h0000_0005);
    apb(1'b1, IDX_A_LOW, 32'h0000_00FE);
    apb(1'b1, IDX_A_HIGH, 32'h0000_0000);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0050);
    want.irqA <= 1'b0;
    edges(2);
    rdc(IDX_A_LOW, 32'h0000_00FE);
    rdc(IDX_RUNFLAG, 32'h0000_0052);
    rdc(IDX_B_LOW, 32'h0000_0005);
    want.irqA <= 1'b1;
    edges(3);
    rdc(IDX_A_LOW, 32'h0000_0001);
    rdc(IDX_A_HIGH, 32'h0000_0001);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0004);
    want.irqB <= 1'b0;
    cyc(5);
    want.irqB <= 1'b1;
    cyc(5);
    rdc(IDX_RUNFLAG, 32'h0000_000C);
    vecExtB <= 1'b1;
    @(posedge mclk);
    vecExtB <= 1'b0;
    @(posedge mclk);
    rdc(IDX_RUNFLAG, 32'h0000_0004);
    apb(1'b1, IDX_MODECFG, 32'h0000_0013);
    apb(1'b1, IDX_IRQ_STAT, 32'h0000_000F);
    apb(1'b1, IDX_A_HIGH, 32'h0000_00FE);
    apb(1'b1, IDX_A_LOW, 32'h0000_0010);
    apb(1'b1, IDX_B_LOW, 32'h0000_0000);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0040);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0080);
    rdc(IDX_A_HIGH, 32'h0000_0001);
    rdc(IDX_A_LOW, 32'h0000_0010);
    rdc(IDX_B_LOW, 32'h0000_0003);
    rdc(IDX_RUNFLAG, 32'h0000_0080);
    rdc(IDX_IRQ_STAT, 32'h0000_0002);
    check({31'h0000_0000, err}, 32'h0000_0000);
    vecAckB <= 1'b1;
    @(posedge mclk);
    vecAckB <= 1'b0;
    @(posedge mclk);
    rdc(IDX_RUNFLAG, 32'h0000_0000);
    apb(1'b1, IDX_MODECFG, 32'h0000_00D1);
    apb(1'b1, IDX_B_LOW, 32'h0000_0000);
    apb(1'b1, IDX_RUNFLAG, 32'h0000_0040);
    want.irqB <= 1'b0;
    edges_b(2);
    rdc(IDX_B_LOW, 32'h0000_0000);
    want.irqB <= 1'b1;
    edges_b(3);
    rdc(IDX_B_LOW, 32'h0000_0003);
    final_report();
  end
endmodule : test_dual_timer_counter_ext_irq
